// file: rtl/fhp_delay.sv
// fhp_delay: one-shot delay counter in units of base ticks
// assumes tick_i is a one-cycle enable pulse
`timescale 1ns/1ps
module fhp_delay
  import fhp_pkg::*;
#(
  parameter int W = 12
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [W-1:0] ticks_i,
  input wire logic tick_i,
  output logic done_o
);
  logic [W-1:0] count;
  logic run;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= '0;
      run <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        count <= ticks_i;
        run <= 1'b1;
      end else if (run && tick_i) begin
        if (count <= {{(W-1){1'b0}}, 1'b1}) begin
          run <= 1'b0;
          done_o <= 1'b1;
        end else begin
          count <= count - 1'b1;
        end
      end
    end
  end
endmodule

// file: rtl/fhp_pkg.sv
// fhp_pkg: shared constants for the head positioning control block
// assumes a 100 MHz core clock and 32-bit AXI4-Lite register access
package fhp_pkg;
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 125;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_RES = 8'h08;
  localparam logic [7:0] ADDR_SPEC = 8'h0C;
  localparam logic [7:0] ADDR_PCYL = 8'h10;
  localparam logic [7:0] ADDR_IDF = 8'h14;
  localparam logic [7:0] ADDR_CTRL = 8'h18;
  localparam logic [3:0] OP_READ_ID = 4'hA;
  localparam logic [3:0] OP_RECAL = 4'h7;
  localparam logic [3:0] OP_SEEK = 4'hF;
  localparam logic [3:0] OP_SENSE_INT = 4'h8;
  localparam logic [3:0] OP_SENSE_DRV = 4'h4;
  localparam logic [3:0] OP_SPECIFY = 4'h3;
  localparam logic [1:0] CAUSE_NORMAL = 2'h0;
  localparam logic [1:0] CAUSE_ABNORMAL = 2'h1;
  localparam logic [1:0] CAUSE_INVALID = 2'h2;
  localparam logic [1:0] CAUSE_POLL = 2'h3;
  localparam logic [6:0] RECAL_MAX_STEPS = 7'h4F;
  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [1:0] RATE_300K = 2'h1;
  localparam logic [1:0] RATE_250K = 2'h2;
  localparam logic [1:0] RATE_1M = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int STEP_PULSE_CYCLES = 4;
  localparam int RATE_FIELD_POS = 4;
  localparam int NODMA_FIELD_POS = 2;
  localparam int LOWPWR_FIELD_POS = 3;
  localparam int RES_PCYL_POS = 8;
  localparam int RES_ST3_POS = 16;
  localparam int PEND_DRIVES = 4;
endpackage

// file: rtl/fhp_top.sv
// fhp_top: control commands, head stepping, interrupt cause and timers
// assumes drive pins are asynchronous; host reaches it over AXI4-Lite
// How it works
// R1 - interrupt only after read id, recal, seek
// R2 - read id captures first good id field
// R3 - no address mark by second index: abnormal
// R4 - recal clears cylinder, steps out until track zero
// R5 - track zero high ends recal with done
// R6 - after 79 steps recal sets done, stuck
// R7 - busy in command phase, free during stepping
// R8 - seek picks direction from cylinder compare
// R9 - steps spaced by step rate, stop on equal
// R10 - cylinder counter follows each step
// R11 - head bit reads zero after seeks
// R12 - leaving low power clears cylinder and status
// R13 - interrupt pin on seek end or transfer need
// R14 - sense interrupt clears pin, returns cause
// R15 - cause codes: poll 11, normal 00, abnormal 01
// R16 - unsensed drive stays marked busy; any sense interrupt clears the mark of every drive
// R17 - host must sense interrupt after seek
// R18 - host recalibrates after power up
// R19 - sense drive status returns status three at once
// R20 - specify loads unload, step, load timers
// R21 - unload and step scale with data rate; of the two only step is scaled, the unload code is stored but drives no timer
// R22 - head load code scaled, zero means 128
// R23 - no dma bit picks transfer signalling
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module fhp_top
  import fhp_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic track_zero_input_i,
  input wire logic index_pulse_input_i,
  input wire logic id_valid_i,
  input wire logic [31:0] id_field_i,
  input wire logic [7:0] drive_status_i,
  input wire logic xfer_need_i,
  output logic step_dir_o,
  output logic step_o,
  output logic head_load_o,
  output logic interrupt_pin_o,
  output logic transfer_request_pin_o,
  output logic request_for_master_o
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_STEP = 5'b00010,
    ST_WAIT = 5'b00100,
    ST_LOAD = 5'b01000,
    ST_RDID = 5'b10000
  } fhp_state_t;

  logic [1:0] rst_sync;
  logic rst_n;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) rst_sync <= 2'b00;
    else rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // track zero, index and drive status pins: two flops before any use
  logic [1:0] tz_s, ix_s;
  logic ix_d;
  logic [7:0] ds_s0, ds_s1;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tz_s <= 2'b00;
      ix_s <= 2'b00;
      ix_d <= 1'b0;
      ds_s0 <= 8'h00;
      ds_s1 <= 8'h00;
    end else begin
      tz_s <= {tz_s[0], track_zero_input_i};
      ix_s <= {ix_s[0], index_pulse_input_i};
      ix_d <= ix_s[1];
      ds_s0 <= drive_status_i;
      ds_s1 <= ds_s0;
    end
  end
  wire track_zero = tz_s[1];
  wire index_rise = ix_s[1] & ~ix_d;

  // base tick of 125 us; slower rates stretch tick count
  logic [15:0] div_cnt;
  logic tick;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= '0;
      tick <= 1'b0;
    end else if (div_cnt == 16'(TICK_DIV - 1)) begin
      div_cnt <= '0;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

  // registers
  logic [3:0] step_rate_code, head_unload_code;
  logic [6:0] head_load_code;
  logic no_dma_select, low_power;
  logic [1:0] rate_sel;
  logic [7:0] present_cylinder, target_cylinder;
  logic [31:0] id_capture;
  logic [7:0] result_status_first;
  logic [7:0] st3;
  logic missing_address_flag;
  logic [PEND_DRIVES-1:0] drive_pending;
  logic [1:0] cur_drive;
  logic busy;
  fhp_state_t state;

  // axi slave
  logic aw_hold, w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire wr_go = aw_hold && w_hold && !s_axi_bvalid_o;
  wire rd_go = s_axi_arvalid_i && s_axi_arready_o;
  wire cmd_wr = wr_go && aw_addr == ADDR_CMD && w_strb[0];
  wire [3:0] cmd_op = w_data[3:0];
  wire cmd_ok = cmd_wr && !busy;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_go) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= (aw_addr == ADDR_CMD || aw_addr == ADDR_SPEC ||
                          aw_addr == ADDR_CTRL) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= RESP_OKAY;
      case (s_axi_araddr_i)
        ADDR_STAT: s_axi_rdata_o <= {24'h0, busy, state != ST_IDLE,
                                     missing_address_flag, 1'b0,
                                     drive_pending};
        ADDR_RES: s_axi_rdata_o <= {8'h0, st3, present_cylinder,
                                    result_status_first};
        ADDR_SPEC: s_axi_rdata_o <= {17'h0, head_load_code,
                                     head_unload_code, step_rate_code};
        ADDR_PCYL: s_axi_rdata_o <= {24'h0, present_cylinder};
        ADDR_IDF: s_axi_rdata_o <= id_capture;
        ADDR_CTRL: s_axi_rdata_o <= {26'h0, rate_sel, low_power,
                                     no_dma_select, 2'b00};
        default: begin
          s_axi_rdata_o <= '0;
          s_axi_rresp_o <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // specify and control
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      step_rate_code <= '0;
      head_unload_code <= '0;
      head_load_code <= '0;
      no_dma_select <= 1'b0;
      low_power <= 1'b0;
      rate_sel <= RATE_500K;
    end else begin
      if (cmd_ok && cmd_op == OP_SPECIFY) begin
        step_rate_code <= w_data[11:8]; // [R20]
        head_unload_code <= w_data[15:12];
        head_load_code <= w_data[22:16];
      end
      if (wr_go && aw_addr == ADDR_CTRL && w_strb[0]) begin
        no_dma_select <= w_data[NODMA_FIELD_POS]; // [R23]
        low_power <= w_data[LOWPWR_FIELD_POS];
        rate_sel <= w_data[RATE_FIELD_POS +: 2];
      end
    end
  end
  wire lp_exit = wr_go && aw_addr == ADDR_CTRL && w_strb[0] &&
                 low_power && !w_data[LOWPWR_FIELD_POS];

  // ticks of 125 us at 1M, scaled: 500K x2, 300K x10/3, 250K x4
  function automatic logic [13:0] scale(input logic [10:0] t1m,
                                        input logic [1:0] r);
    logic [13:0] t;
    t = {3'b000, t1m};
    case (r)
      RATE_1M: scale = t;
      RATE_500K: scale = 14'(t << 1);
      RATE_300K: scale = 14'((t * 10) / 3);
      RATE_250K: scale = 14'(t << 2);
      default: scale = t;
    endcase
  endfunction
  // step (16-code) x 0.5 ms = 4 ticks each [R21]
  wire [10:0] step_1m = {4'h0, 5'h10 - {1'b0, step_rate_code}, 2'b00};
  wire [10:0] hlt_1m = (head_load_code == 7'h00) ? 11'h400 :
                       {1'b0, head_load_code, 3'b000}; // [R22]
  wire [13:0] step_ticks = scale(step_1m, rate_sel); // [R21]
  wire [13:0] load_ticks = scale(hlt_1m, rate_sel); // [R22]

  logic dly_start;
  logic [13:0] dly_ticks;
  logic dly_done;
  fhp_delay #(.W(14)) u_delay (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .start_i(dly_start),
    .ticks_i(dly_ticks),
    .tick_i(tick),
    .done_o(dly_done)
  );

  // stepping engine
  logic is_recal, seek_done_ev, seek_abn_ev;
  logic [6:0] step_count;
  logic [2:0] pulse_cnt;
  logic [1:0] idx_seen;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      present_cylinder <= '0;
      target_cylinder <= '0;
      step_dir_o <= 1'b0;
      step_o <= 1'b0;
      head_load_o <= 1'b0;
      is_recal <= 1'b0;
      step_count <= '0;
      pulse_cnt <= '0;
      seek_done_ev <= 1'b0;
      seek_abn_ev <= 1'b0;
      dly_start <= 1'b0;
      dly_ticks <= '0;
      cur_drive <= '0;
      idx_seen <= '0;
      id_capture <= '0;
      missing_address_flag <= 1'b0;
      busy <= 1'b0;
    end else begin
      seek_done_ev <= 1'b0;
      seek_abn_ev <= 1'b0;
      dly_start <= 1'b0;
      busy <= 1'b0; // [R7]
      if (pulse_cnt != 3'h0) pulse_cnt <= pulse_cnt - 3'h1;
      else step_o <= 1'b0;
      if (lp_exit) present_cylinder <= '0; // [R12]
      case (state)
        ST_IDLE: begin
          if (cmd_ok && cmd_op == OP_RECAL) begin
            present_cylinder <= '0; // [R4]
            step_dir_o <= 1'b0;
            is_recal <= 1'b1;
            step_count <= '0;
            cur_drive <= w_data[9:8];
            state <= ST_STEP;
          end else if (cmd_ok && cmd_op == OP_SEEK) begin
            target_cylinder <= w_data[23:16];
            is_recal <= 1'b0;
            cur_drive <= w_data[9:8];
            state <= ST_STEP;
          end else if (cmd_ok && cmd_op == OP_READ_ID) begin
            head_load_o <= 1'b1;
            dly_ticks <= load_ticks;
            dly_start <= 1'b1;
            missing_address_flag <= 1'b0;
            cur_drive <= w_data[9:8];
            state <= ST_LOAD;
          end
        end
        ST_STEP: begin
          if (is_recal) begin
            if (track_zero) begin
              seek_done_ev <= 1'b1; // [R5]
              state <= ST_IDLE;
            end else if (step_count == RECAL_MAX_STEPS) begin
              seek_abn_ev <= 1'b1; // [R6]
              state <= ST_IDLE;
            end else begin
              step_o <= 1'b1; // [R4]
              pulse_cnt <= 3'(STEP_PULSE_CYCLES);
              step_count <= step_count + 7'h01;
              dly_ticks <= step_ticks;
              dly_start <= 1'b1;
              state <= ST_WAIT;
            end
          end else if (present_cylinder == target_cylinder) begin
            seek_done_ev <= 1'b1; // [R9]
            state <= ST_IDLE;
          end else begin
            step_dir_o <= present_cylinder < target_cylinder; // [R8]
            step_o <= 1'b1;
            pulse_cnt <= 3'(STEP_PULSE_CYCLES);
            if (present_cylinder < target_cylinder)
              present_cylinder <= present_cylinder + 8'h01; // [R10]
            else
              present_cylinder <= present_cylinder - 8'h01; // [R10]
            dly_ticks <= step_ticks;
            dly_start <= 1'b1;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: if (dly_done) state <= ST_STEP; // [R9]
        ST_LOAD: if (dly_done) begin
          idx_seen <= '0;
          state <= ST_RDID;
        end
        ST_RDID: begin
          busy <= 1'b1;
          if (id_valid_i) begin
            id_capture <= id_field_i; // [R2]
            state <= ST_IDLE;
          end else if (index_rise) begin
            if (idx_seen == 2'h1) begin
              missing_address_flag <= 1'b1; // [R3]
              state <= ST_IDLE;
            end
            idx_seen <= idx_seen + 2'h1;
          end
        end
        default: state <= ST_IDLE;
      endcase
      if (cmd_wr && !busy) busy <= 1'b1; // [R7]
    end
  end
  wire rdid_end = state == ST_RDID && (id_valid_i ||
                  (index_rise && idx_seen == 2'h1));
  wire rdid_abn = state == ST_RDID && !id_valid_i &&
                  index_rise && idx_seen == 2'h1;

  // interrupt cause and result status
  logic int_flag;
  logic [1:0] cause;
  logic pos_done, stuck;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      int_flag <= 1'b0;
      cause <= CAUSE_POLL;
      pos_done <= 1'b0;
      stuck <= 1'b0;
      drive_pending <= '0;
      result_status_first <= '0;
      st3 <= '0;
    end else begin
      // low power exit first, so a same-cycle seek end still sets
      if (lp_exit) begin
        drive_pending <= '0; // [R12]
        pos_done <= 1'b0;
        stuck <= 1'b0;
        cause <= CAUSE_POLL;
        result_status_first <= '0;
        int_flag <= 1'b0;
      end
      if (cmd_ok && cmd_op == OP_SENSE_INT) begin
        // head bit forced zero in returned status [R11]
        result_status_first <= {cause, pos_done, stuck, 2'b00,
                                cur_drive}; // [R14] [R15]
        int_flag <= 1'b0; // [R14]
        drive_pending <= '0;
        pos_done <= 1'b0;
        stuck <= 1'b0;
        cause <= CAUSE_POLL;
      end
      if (cmd_ok && cmd_op == OP_SENSE_DRV)
        st3 <= ds_s1; // [R19]
      if (cmd_ok && !(cmd_op inside {OP_SENSE_INT, OP_SENSE_DRV,
          OP_SPECIFY, OP_READ_ID, OP_RECAL, OP_SEEK}))
        result_status_first <= {CAUSE_INVALID, 6'h00};
      // set wins over sense clear [R1] [R13]
      if (seek_done_ev || seek_abn_ev) begin
        int_flag <= 1'b1;
        pos_done <= 1'b1; // [R5] [R9]
        stuck <= seek_abn_ev; // [R6]
        cause <= seek_abn_ev ? CAUSE_ABNORMAL : CAUSE_NORMAL; // [R15]
        drive_pending[cur_drive] <= 1'b1; // [R16]
      end
      if (rdid_end) begin
        int_flag <= 1'b1; // [R1]
        cause <= rdid_abn ? CAUSE_ABNORMAL : CAUSE_NORMAL; // [R3]
        pos_done <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_pin_o <= 1'b0;
      transfer_request_pin_o <= 1'b0;
      request_for_master_o <= 1'b0;
    end else begin
      // [R13] [R23]
      interrupt_pin_o <= int_flag || (no_dma_select && xfer_need_i);
      transfer_request_pin_o <= !no_dma_select && xfer_need_i;
      request_for_master_o <= !busy || (no_dma_select && xfer_need_i);
    end
  end

  // assertions
  sequence step_issued_s;
    state == ST_STEP && !is_recal && present_cylinder != target_cylinder;
  endsequence
  sequence step_in_s;
    state == ST_STEP && !is_recal && present_cylinder < target_cylinder;
  endsequence
  sequence step_spaced_s;
    !step_o [*5];
  endsequence
  dir_in_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R8]
    step_in_s |=> step_dir_o)
    else $error("seek inward without dir high");
  cyl_track_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    step_issued_s |=> present_cylinder != $past(present_cylinder)) // [R10]
    else $error("cylinder not updated on step");
  spacing_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    $rose(step_o) |=> step_o [*4] ##1 step_spaced_s) // [R9]
    else $error("step pulses too close");
  recal_dir_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (state == ST_WAIT && is_recal) |-> !step_dir_o) // [R4]
    else $error("recal stepping inward");
  recal_cap_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    is_recal |-> step_count <= RECAL_MAX_STEPS) // [R6]
    else $error("recal exceeded step limit");
  stuck_set_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    seek_abn_ev |=> stuck && pos_done && cause == CAUSE_ABNORMAL) // [R6]
    else $error("stuck head status wrong");
  done_int_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    seek_done_ev |=> ##1 interrupt_pin_o) // [R13]
    else $error("no interrupt after seek end");
  sense_clr_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (cmd_ok && cmd_op == OP_SENSE_INT && !seek_done_ev && !seek_abn_ev &&
     !rdid_end && !xfer_need_i) |=> ##1 !interrupt_pin_o) // [R14]
    else $error("sense did not clear interrupt");
  head_zero_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    result_status_first[2] == 1'b0) // [R11]
    else $error("head bit set in status");
  dma_mode_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    no_dma_select |=> !transfer_request_pin_o) // [R23]
    else $error("dma request in non-dma mode");
endmodule

// file: sim/fhp_drive_model.sv
// fhp_drive_model: behavioural floppy drive at the far side of the block
// assumes step and direction from the block; the bench presets pos/stuck
`timescale 1ns/1ps
module fhp_drive_model #(
  parameter logic [7:0] STATUS = 8'hA5,
  parameter logic [31:0] ID = 32'h1203_0502
) (
  input wire logic clk_i,
  input wire logic step_i,
  input wire logic dir_i,
  output logic track_zero_o,
  output logic index_o = 1'b0,
  output logic id_valid_o = 1'b0,
  output logic [31:0] id_field_o = 32'h0000_0000,
  output logic [7:0] status_o
);
  int pos = 0;
  int steps = 0;
  int phase = 0;
  bit stuck = 1'b0;
  bit has_id = 1'b0;
  time mark = 0;
  int gap = 0;
  // head moves one track per step, never below track zero
  always @(posedge step_i) begin
    steps <= steps + 1;
    // spacing of the last two steps, in 10 ns clock periods
    gap <= int'(($time - mark) / 10);
    mark <= $time;
    pos <= dir_i ? pos + 1 : (pos > 0 ? pos - 1 : 0);
  end
  // stuck head never reports track zero
  assign track_zero_o = (pos == 0) && !stuck;
  assign status_o = STATUS;
  // spindle turns freely, one index every 100 cycles
  always @(posedge clk_i) begin
    phase <= (phase == 99) ? 0 : phase + 1;
    index_o <= phase < 4;
    id_valid_o <= has_id && phase == 20;
    // field is not held outside its pulse
    id_field_o <= (has_id && phase == 20) ? ID : ~id_field_o;
  end
endmodule

// file: sim/tb_top.sv
// tb_top: host-side bench driving commands over AXI4-Lite
// assumes fhp_top with a short tick and the drive model beside it
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
  end \
end
module tb_top;
  import fhp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, xfer = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, dir, step, hl;
  logic irq, treq, rfm, t0, idx, idv;
  logic [1:0] bresp, rresp, rr;
  logic [31:0] rdata, idf, rdat;
  logic [7:0] dst;
  int bad_count = 0;
  int n_compared = 0;
  int tg[2] = '{10, 3};
  // step ticks (4 at 1M, 13 at 300K) times the bench divider of 4
  int gp[2] = '{16, 52};
  int pv = 0;
  initial forever #5 clk = ~clk;
  fhp_top #(.TICK_DIV(4)) dut (
    .ref_clk_i(clk), .rst_n_i(rst_n),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(1'b1),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(1'b1), .track_zero_input_i(t0),
    .index_pulse_input_i(idx), .id_valid_i(idv), .id_field_i(idf),
    .drive_status_i(dst), .xfer_need_i(xfer), .step_dir_o(dir),
    .step_o(step), .head_load_o(hl), .interrupt_pin_o(irq),
    .transfer_request_pin_o(treq), .request_for_master_o(rfm)
  );
  fhp_drive_model drv (
    .clk_i(clk), .step_i(step), .dir_i(dir), .track_zero_o(t0),
    .index_o(idx), .id_valid_o(idv), .id_field_o(idf), .status_o(dst)
  );
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic hang;
    bad_count++;
    $display("CHECK FAILED wait exp 1 got 0");
    stop_test();
  endtask
  // bready and rready stay high, so only the request side moves
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 200);
    if (n >= 200) hang();
  endtask
  task automatic rd_reg(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 200);
    rdat = rdata;
    rr = rresp;
    if (n >= 200) hang();
  endtask
  task automatic cmd(input logic [3:0] op, input logic [7:0] t);
    wr(ADDR_CMD, {8'h00, t, 12'h000, op});
  endtask
  task automatic sense;
    cmd(OP_SENSE_INT, 8'h00);
    repeat (4) @(posedge clk);
    rd_reg(ADDR_RES);
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 5000) hang();
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    wr(ADDR_CTRL, 32'h0000_0030);
    cmd(OP_SPECIFY, 8'h01);
    wr(ADDR_CMD, 32'h0001_FF03);
    `CHK("bresp", RESP_OKAY, bresp)
    repeat (4) @(posedge clk);
    rd_reg(ADDR_SPEC);
    `CHK("spec", 15'h01FF, rdat[14:0])
    `CHK("irq", 1'b0, irq)
    $display("specify test done");
    drv.pos = 5;
    cmd(OP_RECAL, 8'h00);
    wait_irq();
    `CHK("head", 0, drv.pos)
    rd_reg(ADDR_STAT);
    `CHK("pend", 1'b1, rdat[0])
    sense();
    `CHK("res", 8'h20, rdat[7:0])
    `CHK("irq", 1'b0, irq)
    $display("recalibrate test done");
    foreach (tg[i]) begin
      wr(ADDR_CTRL, (i == 0) ? 32'h0000_0030 : 32'h0000_0010);
      cmd(OP_SEEK, 8'(tg[i]));
      repeat (3) @(posedge clk);
      rd_reg(ADDR_STAT);
      `CHK("busy", 2'b01, rdat[7:6])
      wait_irq();
      `CHK("dir", tg[i] > pv, dir)
      `CHK("head", tg[i], drv.pos)
      `CHK("gap", gp[i], drv.gap)
      sense();
      `CHK("res", 8'h20, rdat[7:0])
      `CHK("cyl", 8'(tg[i]), rdat[15:8])
      pv = tg[i];
    end
    $display("seek test done");
    wr(ADDR_CTRL, 32'h0000_0038);
    wr(ADDR_CTRL, 32'h0000_0030);
    rd_reg(ADDR_PCYL);
    `CHK("cyl", 8'h00, rdat[7:0])
    drv.stuck = 1'b1;
    drv.pos = 100;
    drv.steps = 0;
    cmd(OP_RECAL, 8'h00);
    wait_irq();
    `CHK("steps", 79, drv.steps)
    sense();
    `CHK("res", 8'h70, rdat[7:0])
    drv.stuck = 1'b0;
    $display("stuck head test done");
    cmd(OP_SENSE_DRV, 8'h00);
    repeat (4) @(posedge clk);
    rd_reg(ADDR_RES);
    `CHK("st3", 8'hA5, rdat[23:16])
    `CHK("irq", 1'b0, irq)
    drv.has_id = 1'b1;
    cmd(OP_READ_ID, 8'h00);
    wait_irq();
    rd_reg(ADDR_IDF);
    `CHK("id", 32'h1203_0502, rdat)
    `CHK("load", 1'b1, hl)
    sense();
    drv.has_id = 1'b0;
    cmd(OP_READ_ID, 8'h00);
    wait_irq();
    rd_reg(ADDR_STAT);
    `CHK("miss", 1'b1, rdat[5])
    sense();
    `CHK("cause", 2'b01, rdat[7:6])
    $display("read id test done");
    xfer <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK("dma", 1'b1, treq)
    wr(ADDR_CTRL, 32'h0000_0034);
    repeat (4) @(posedge clk);
    `CHK("nodma", 2'b11, {irq, rfm})
    rd_reg(8'hFC);
    `CHK("resp", RESP_SLVERR, rr)
    wr(8'hFC, 32'h0000_0000);
    `CHK("bresp", RESP_SLVERR, bresp)
    cmd(4'h1, 8'h00);
    repeat (4) @(posedge clk);
    rd_reg(ADDR_RES);
    `CHK("bad op", 8'h80, rdat[7:0])
    $display("transfer mode test done");
    stop_test();
  end
endmodule
